// [hw/uiesu_top.sv]
// UART interrupt enable, prioritised status and line status flags
// Operation
// - FIFO level at trigger raises receive interrupt
// - Data ready set on push, clear empty
// - FIFO on, low enables clear: polled mode
// - Line flags report overrun, errors, transmit empties
// - Receive enable gates holding/trigger data interrupt
// - Transmit enable gates ready; enabling while ready fires immediately
// - Line enable interrupts on line bits 1-4,7
// - Summary flag for errored chars; head errors
// - Modem enable interrupts on change bits 0-3
// - Enables 7:4 writable only with enhanced; sleep
// - Xoff enable interrupts on Xoff/special match
// - RTS enable interrupts on RTS rising
// - CTS enable interrupts on CTS rising
// - Status read shows highest pending source only
// - Time-out after four chars plus twelve bits
// - GPIO toggle interrupts, cleared by pin read
// - Line clears when errors gone; rx below
// - Transmit ready cleared by status read, write
// - Modem and flow interrupts cleared modem read
// - Xoff held until Xon; special cleared read
// - Status codes by priority; 0x01 means none
// - Xoff status sets only with both enables
// - Top status bits show FIFO enable
// - Status bit 5 flags CTS/RTS deassert
`timescale 1ns/1ns
module uiesu_top
  import uiesu_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Host register port
  input  wire logic [3:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            host_irq,
  // Mode controls from the rest of the channel
  input  wire logic       fifo_enable,
  input  wire logic       enhanced_enable,
  input  wire logic       auto_rts,
  input  wire logic       auto_cts,
  // Receive path state
  input  wire logic [6:0] rx_level,
  input  wire logic [6:0] rx_trigger,
  input  wire logic       rx_push,
  input  wire logic       rx_overrun,
  input  wire logic [2:0] rx_head_error,
  input  wire logic [6:0] rx_error_count,
  input  wire logic       bit_tick,
  input  wire logic [3:0] char_bits,
  // Transmit path state
  input  wire logic [6:0] tx_spaces,
  input  wire logic [6:0] tx_trigger,
  input  wire logic       transmit_holding_empty,
  input  wire logic       transmit_shift_empty,
  // Other interrupt sources
  input  wire logic [3:0] modem_delta,
  input  wire logic [7:0] gpio_in,
  input  wire logic       xoff_match,
  input  wire logic       special_match,
  input  wire logic       xon_match,
  input  wire logic       rts_n,
  input  wire logic       cts_n,
  // Status seen by the rest of the channel
  output logic            sleep_enable,
  output logic            polled_mode
);

  // Enable register and sticky source flags
  logic [7:0]            interrupt_enable;
  logic                  overrun_flag;
  logic                  tx_pend;
  logic                  tx_cond_q;
  logic                  timeout_pend;
  logic [UIESU_TO_W-1:0] timeout_cnt;
  logic [7:0]            gpio_q;
  logic                  gpio_pend;
  logic                  xoff_pend;
  logic                  special_pend;
  logic                  rts_q;
  logic                  cts_q;
  logic                  flow_pend;

  // Host access decode
  wire logic acc_ier_wr    = reg_wr && (reg_addr == UIESU_OFS_IER);
  wire logic acc_thr_wr    = reg_wr && (reg_addr == UIESU_OFS_HOLDING);
  wire logic acc_rhr_rd    = reg_rd && (reg_addr == UIESU_OFS_HOLDING);
  wire logic acc_isr_rd    = reg_rd && (reg_addr == UIESU_OFS_ISR);
  wire logic acc_line_rd   = reg_rd && (reg_addr == UIESU_OFS_LINE);
  wire logic acc_modem_rd  = reg_rd && (reg_addr == UIESU_OFS_MODEM);
  wire logic acc_io_rd     = reg_rd && (reg_addr == UIESU_OFS_IO_STATE);

  // Upper enables only move while enhanced functions are on
  wire logic [7:0] ier_keep_msk = enhanced_enable ? 8'h00 : ~UIESU_IE_BASE_MSK;
  wire logic [7:0] next_ier     = (interrupt_enable & ier_keep_msk)
                                | (reg_wdata & ~ier_keep_msk);

  // Line status flags
  wire logic       data_ready   = (rx_level != 7'h00);
  wire logic       err_summary  = (rx_error_count != 7'h00);
  wire logic       tx_all_empty = transmit_holding_empty && transmit_shift_empty;
  wire logic [7:0] line_status  = {err_summary, tx_all_empty, transmit_holding_empty,
                                   rx_head_error, overrun_flag, data_ready};

  // Receive data condition: level in FIFO mode, any char otherwise
  wire logic rx_cond = fifo_enable ? (rx_level >= rx_trigger) : data_ready;

  // Transmit ready condition: spaces above trigger or empty FIFO
  wire logic tx_cond = fifo_enable ? ((tx_spaces > tx_trigger) || transmit_holding_empty)
                                   : transmit_holding_empty;

  // Line condition follows overrun, head errors and summary
  wire logic line_cond = overrun_flag || (rx_head_error != 3'h0) || err_summary;

  // Time-out span in bit times, recomputed from the frame length
  wire logic [UIESU_TO_W-1:0] timeout_span =
    UIESU_TO_W'(UIESU_TO_CHARS) * UIESU_TO_W'(char_bits) + UIESU_TO_W'(UIESU_TO_BITS);
  wire logic timeout_run = fifo_enable && data_ready;

  // Edge detectors on the flow-control pins, toggle detector on the general inputs
  wire logic rts_rise   = auto_rts && rts_n && !rts_q;
  wire logic cts_rise   = auto_cts && cts_n && !cts_q;
  wire logic gpio_tog   = (gpio_in != gpio_q);

  // Enabled requests per priority level
  wire logic req_line    = interrupt_enable[UIESU_IE_LINE]  && line_cond;
  wire logic req_timeout = interrupt_enable[UIESU_IE_RX]    && timeout_pend;
  wire logic req_rx      = interrupt_enable[UIESU_IE_RX]    && rx_cond;
  wire logic req_tx      = interrupt_enable[UIESU_IE_TX]    && tx_pend;
  wire logic req_modem   = interrupt_enable[UIESU_IE_MODEM] && (modem_delta != 4'h0);
  wire logic req_gpio    = gpio_pend;
  wire logic req_xoff    = xoff_pend || special_pend;
  wire logic req_flow    = flow_pend && enhanced_enable;

  // Priority encoder: only the top pending source is reported
  wire logic [5:0] isr_code =
    req_line    ? UIESU_ISR_LINE    :
    req_timeout ? UIESU_ISR_TIMEOUT :
    req_rx      ? UIESU_ISR_RECEIVE_READY_IRQ   :
    req_tx      ? UIESU_ISR_TRANSMIT_READY_IRQ   :
    req_modem   ? UIESU_ISR_MODEM   :
    req_gpio    ? UIESU_ISR_GPIO    :
    req_xoff    ? UIESU_ISR_XOFF    :
    req_flow    ? UIESU_ISR_FLOW    : UIESU_ISR_NONE;
  wire logic [7:0] interrupt_status =
    {fifo_enable ? UIESU_ISR_FIFO_ON : 2'h0, isr_code};

  // Reads that report a source acknowledge only that source
  wire logic isr_ack_tx   = acc_isr_rd && (isr_code == UIESU_ISR_TRANSMIT_READY_IRQ);
  wire logic isr_ack_spec = acc_isr_rd && (isr_code == UIESU_ISR_XOFF);

  // Read data mux; other addresses belong elsewhere and read zero here
  wire logic [7:0] rd_mux =
    (reg_addr == UIESU_OFS_IER)  ? interrupt_enable :
    (reg_addr == UIESU_OFS_ISR)  ? interrupt_status :
    (reg_addr == UIESU_OFS_LINE) ? line_status      : 8'h00;

  // Interrupt enable register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      interrupt_enable <= UIESU_IE_RESET;
    end else if (acc_ier_wr) begin
      interrupt_enable <= next_ier;
    end
  end

  // Overrun is sticky until the line status is read; a new one wins
  // The flag lives here since the receive path only pulses it
  wire logic next_overrun = rx_overrun || (overrun_flag && !acc_line_rd);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      overrun_flag <= 1'b0;
    end else begin
      overrun_flag <= next_overrun;
    end
  end

  // Transmit ready: set on rising condition or when enabled while empty
  wire logic tx_en_rise   = acc_ier_wr && next_ier[UIESU_IE_TX] && !interrupt_enable[UIESU_IE_TX];
  wire logic tx_set       = (tx_cond && !tx_cond_q) || (tx_en_rise && tx_cond);
  wire logic next_tx_pend = tx_set || (tx_pend && !acc_thr_wr && !isr_ack_tx);

  // Last transmit condition; resets high, as an idle channel is empty,
  // so that leaving reset does not look like a fresh rising condition
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_cond_q <= 1'b1;
    end else begin
      tx_cond_q <= tx_cond;
    end
  end

  // Transmit ready flag, kept even while masked so enabling can report it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_pend <= 1'b0;
    end else begin
      tx_pend <= next_tx_pend;
    end
  end

  // Receive time-out timer, restarted by each push or read
  // It stops at the span, so an idle FIFO never wraps and fires again
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timeout_cnt <= '0;
    end else if (!timeout_run || rx_push || acc_rhr_rd) begin
      timeout_cnt <= '0;
    end else if (bit_tick && (timeout_cnt != timeout_span)) begin
      timeout_cnt <= timeout_cnt + UIESU_TO_W'(1);
    end
  end

  // Time-out flag clears on a holding register read
  wire logic timeout_hit = timeout_run && bit_tick && !rx_push && !acc_rhr_rd
                         && (timeout_cnt == timeout_span - UIESU_TO_W'(1));
  wire logic next_timeout_pend = timeout_hit || (timeout_pend && !acc_rhr_rd);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      timeout_pend <= 1'b0;
    end else begin
      timeout_pend <= next_timeout_pend;
    end
  end

  // Last sampled general inputs, for toggle detection
  // Reset to zero, so inputs already high at release report a toggle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gpio_q <= 8'h00;
    end else begin
      gpio_q <= gpio_in;
    end
  end

  // GPIO toggle flag, cleared by the pin state read
  wire logic next_gpio_pend = gpio_tog || (gpio_pend && !acc_io_rd);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gpio_pend <= 1'b0;
    end else begin
      gpio_pend <= next_gpio_pend;
    end
  end

  // Xoff waits for Xon; special character waits for a status read
  wire logic xoff_arm          = enhanced_enable && interrupt_enable[UIESU_IE_XOFF];
  wire logic next_xoff_pend    = (xoff_arm && xoff_match) || (xoff_pend && !xon_match);
  wire logic next_special_pend = (xoff_arm && special_match) || (special_pend && !isr_ack_spec);

  // Xoff flag, held until Xon arrives
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xoff_pend <= 1'b0;
    end else begin
      xoff_pend <= next_xoff_pend;
    end
  end

  // Special character flag, held until reported
  // A status read clears it only when it was the code reported
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      special_pend <= 1'b0;
    end else begin
      special_pend <= next_special_pend;
    end
  end

  // Flow-control deassert flag, gated by its own enables
  wire logic flow_set       = (interrupt_enable[UIESU_IE_RTS] && rts_rise)
                            || (interrupt_enable[UIESU_IE_CTS] && cts_rise);
  wire logic next_flow_pend = flow_set || (flow_pend && !acc_modem_rd);

  // Last pin levels; reset high so a pin already high at release is no edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rts_q <= 1'b1;
      cts_q <= 1'b1;
    end else begin
      rts_q <= rts_n;
      cts_q <= cts_n;
    end
  end

  // Flow flag, cleared by the modem status read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flow_pend <= 1'b0;
    end else begin
      flow_pend <= next_flow_pend;
    end
  end

  // Registered read data, one cycle after the read strobe
  // Held between reads so a slow host can sample late
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // Next values of the flopped outputs
  wire logic next_host_irq = (isr_code != UIESU_ISR_NONE);
  wire logic next_polled   = fifo_enable && ((interrupt_enable & UIESU_IE_BASE_MSK) == 8'h00);

  // Host interrupt, one cycle behind the pending sources;
  // a flop here keeps decode glitches off the pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_irq <= 1'b0;
    end else begin
      host_irq <= next_host_irq;
    end
  end

  // Sleep enable copy; sleep itself is handled elsewhere
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sleep_enable <= 1'b0;
    end else begin
      sleep_enable <= interrupt_enable[UIESU_IE_SLEEP];
    end
  end

  // Polled mode indication
  // Host polls the line flags instead of taking interrupts
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      polled_mode <= 1'b0;
    end else begin
      polled_mode <= next_polled;
    end
  end

endmodule

// [hw/uiesu_pkg.sv]
// Constants shared by the UART interrupt enable and status unit
package uiesu_pkg;
  // Register offsets on the host register port
  localparam logic [3:0] UIESU_OFS_HOLDING   = 4'h0;
  localparam logic [3:0] UIESU_OFS_IER       = 4'h1;
  localparam logic [3:0] UIESU_OFS_ISR       = 4'h2;
  localparam logic [3:0] UIESU_OFS_LINE      = 4'h5;
  localparam logic [3:0] UIESU_OFS_MODEM     = 4'h6;
  localparam logic [3:0] UIESU_OFS_IO_STATE  = 4'hB;

  // Interrupt enable field positions
  localparam int UIESU_IE_RX      = 0;
  localparam int UIESU_IE_TX      = 1;
  localparam int UIESU_IE_LINE    = 2;
  localparam int UIESU_IE_MODEM   = 3;
  localparam int UIESU_IE_SLEEP   = 4;
  localparam int UIESU_IE_XOFF    = 5;
  localparam int UIESU_IE_RTS     = 6;
  localparam int UIESU_IE_CTS     = 7;
  localparam logic [7:0] UIESU_IE_RESET    = 8'h00;
  localparam logic [7:0] UIESU_IE_BASE_MSK = 8'h0F;

  // Interrupt status codes in bits 5:0
  localparam logic [5:0] UIESU_ISR_LINE    = 6'h06;
  localparam logic [5:0] UIESU_ISR_TIMEOUT = 6'h0C;
  localparam logic [5:0] UIESU_ISR_RECEIVE_READY_IRQ   = 6'h04;
  localparam logic [5:0] UIESU_ISR_TRANSMIT_READY_IRQ   = 6'h02;
  localparam logic [5:0] UIESU_ISR_MODEM   = 6'h00;
  localparam logic [5:0] UIESU_ISR_GPIO    = 6'h30;
  localparam logic [5:0] UIESU_ISR_XOFF    = 6'h10;
  localparam logic [5:0] UIESU_ISR_FLOW    = 6'h20;
  localparam logic [5:0] UIESU_ISR_NONE    = 6'h01;
  localparam logic [1:0] UIESU_ISR_FIFO_ON = 2'h3;

  // Receive time-out span: characters plus extra bit times
  localparam int UIESU_TO_CHARS = 4;
  localparam int UIESU_TO_BITS  = 12;
  localparam int UIESU_TO_W     = 8;
endpackage

// [dv/uiesu_chk.sv]
// Port assertions for the interrupt enable and status unit
`timescale 1ns/1ns
module uiesu_chk
  import uiesu_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       host_irq,
  input wire logic       fifo_enable,
  input wire logic       enhanced_enable,
  input wire logic [2:0] rx_head_error,
  input wire logic [6:0] rx_error_count,
  input wire logic       transmit_holding_empty,
  input wire logic       transmit_shift_empty,
  input wire logic [7:0] gpio_in,
  input wire logic       sleep_enable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Decoded host accesses
  wire rd_st = reg_rd && reg_addr == UIESU_OFS_ISR;
  wire rd_ln = reg_rd && reg_addr == UIESU_OFS_LINE;
  wire wr_ie = reg_wr && reg_addr == UIESU_OFS_IER;

  AST_ISR_TOP: assert property (rd_st |=> reg_rdata[7:6] == {2{$past(fifo_enable)}})
    else $error("status top bits wrong");
  AST_ISR_CODE: assert property (rd_st |=> reg_rdata[5:0] inside
    {6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h30, 6'h10, 6'h20, 6'h01}) else $error("bad status code");
  AST_IRQ_MATCH: assert property (rd_st |=> reg_rdata[0] == !host_irq)
    else $error("irq disagrees with status");
  AST_LINE_ERR: assert property (rd_ln |=> reg_rdata[4:2] == $past(rx_head_error)
    && reg_rdata[7] == ($past(rx_error_count) != 7'h00)) else $error("line error bits wrong");
  AST_LINE_TX: assert property (rd_ln |=> reg_rdata[6:5] ==
    {$past(transmit_holding_empty && transmit_shift_empty), $past(transmit_holding_empty)})
    else $error("line transmit bits wrong");
  // Upper enables locked while enhanced functions are off
  AST_IER_LOCK: assert property (wr_ie && !enhanced_enable |=> $stable(sleep_enable)[*2])
    else $error("sleep bit changed while locked");
  AST_GPIO_IRQ: assert property (gpio_in != $past(gpio_in) |-> ##[1:3] host_irq)
    else $error("no irq after pin toggle");
  AST_HOLD_DATA: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
endmodule
bind uiesu_top uiesu_chk u_uiesu_chk (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_irq(host_irq),
  .fifo_enable(fifo_enable), .enhanced_enable(enhanced_enable), .rx_head_error(rx_head_error),
  .rx_error_count(rx_error_count), .transmit_holding_empty(transmit_holding_empty),
  .transmit_shift_empty(transmit_shift_empty), .gpio_in(gpio_in), .sleep_enable(sleep_enable));

// [dv/uiesu_host.sv]
// Host processor model on the register port
`timescale 1ns/1ns
module uiesu_host (
  input  wire logic       sys_clk,
  output logic      [3:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;
  end
  // One write, strobe up for exactly one taking edge
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  // Polled read; a short pause first lets flags settle
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    repeat (2) @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    v = reg_rdata;
  endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench for the interrupt enable and status unit
`timescale 1ns/1ns
module testbench;
  import uiesu_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       reg_wr, reg_rd, host_irq, fifo_enable, enhanced_enable, auto_rts, auto_cts, rx_push;
  logic       rx_overrun, bit_tick, transmit_holding_empty, transmit_shift_empty, xoff_match;
  logic       special_match, xon_match, rts_n, cts_n, sleep_enable, polled_mode;
  logic [3:0] reg_addr, modem_delta, char_bits;
  logic [6:0] rx_level, rx_trigger, rx_error_count, tx_spaces, tx_trigger;
  logic [7:0] reg_wdata, reg_rdata, gpio_in, d;
  logic [2:0] rx_head_error;
  int         fail_count, num_checks, cyc;

  uiesu_top u_uiesu_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .host_irq(host_irq),
    .fifo_enable(fifo_enable), .enhanced_enable(enhanced_enable), .auto_rts(auto_rts),
    .auto_cts(auto_cts), .rx_level(rx_level), .rx_trigger(rx_trigger), .rx_push(rx_push),
    .rx_overrun(rx_overrun), .rx_head_error(rx_head_error), .rx_error_count(rx_error_count),
    .bit_tick(bit_tick), .char_bits(char_bits), .tx_spaces(tx_spaces), .tx_trigger(tx_trigger),
    .transmit_holding_empty(transmit_holding_empty), .transmit_shift_empty(transmit_shift_empty),
    .modem_delta(modem_delta), .gpio_in(gpio_in), .xoff_match(xoff_match),
    .special_match(special_match), .xon_match(xon_match), .rts_n(rts_n), .cts_n(cts_n),
    .sleep_enable(sleep_enable), .polled_mode(polled_mode));
  uiesu_host u_uiesu_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  always #50 sys_clk = ~sys_clk;
  // Hang guard, well above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [3:0] a, input logic [7:0] v);
    u_uiesu_host.wr(a, v);
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    u_uiesu_host.rd(a, d);
    chk(d, e);
  endtask
  task automatic t_enh;
    rc(4'h1, 8'h00);
    rc(4'h2, 8'h01);
    w(4'h1, 8'hF1);
    rc(4'h1, 8'h01);
    @(posedge sys_clk) rx_level <= 7'h01;
    rc(4'h2, 8'h04);
    @(posedge sys_clk) rx_level <= 7'h00;
    @(posedge sys_clk) enhanced_enable <= 1'b1;
    w(4'h1, 8'h10);
    rc(4'h1, 8'h10);
    chk({7'h0, sleep_enable}, 8'h01);
  endtask
  // Receive trigger, data ready and polled mode
  task automatic t_rx;
    @(posedge sys_clk) fifo_enable <= 1'b1;
    rx_level <= 7'h08;
    rx_push <= 1'b1;
    @(posedge sys_clk) rx_push <= 1'b0;
    w(4'h1, 8'h01);
    rc(4'h2, 8'hC4);
    chk({7'h0, host_irq}, 8'h01);
    @(posedge sys_clk) rx_level <= 7'h07;
    rc(4'h2, 8'hC1);
    rc(4'h5, 8'h01);
    @(posedge sys_clk) rx_level <= 7'h00;
    w(4'h1, 8'h00);
    rc(4'h5, 8'h00);
    chk({7'h0, polled_mode}, 8'h01);
  endtask
  // Line errors outrank receive data; overrun is sticky
  task automatic t_line;
    @(posedge sys_clk) rx_level <= 7'h08;
    rx_push <= 1'b1;
    rx_error_count <= 7'h01;
    rx_head_error <= 3'h5;
    @(posedge sys_clk) rx_push <= 1'b0;
    w(4'h1, 8'h05);
    rc(4'h2, 8'hC6);
    rc(4'h5, 8'h95);
    @(posedge sys_clk) rx_error_count <= 7'h00;
    rx_head_error <= 3'h0;
    rc(4'h2, 8'hC4);
    @(posedge sys_clk) rx_overrun <= 1'b1;
    @(posedge sys_clk) rx_overrun <= 1'b0;
    rc(4'h2, 8'hC6);
    rc(4'h5, 8'h03);
    rc(4'h2, 8'hC4);
    @(posedge sys_clk) rx_level <= 7'h00;
    w(4'h1, 8'h00);
  endtask
  task automatic t_tx;
    @(posedge sys_clk) transmit_holding_empty <= 1'b1;
    transmit_shift_empty <= 1'b1;
    w(4'h1, 8'h02);
    rc(4'h2, 8'hC2);
    rc(4'h2, 8'hC1);
    w(4'h1, 8'h00);
    w(4'h1, 8'h02);
    w(4'h0, 8'h55);
    rc(4'h2, 8'hC1);
    w(4'h1, 8'h00);
    w(4'h1, 8'h02);
    rc(4'h2, 8'hC2);
    rc(4'h5, 8'h60);
    w(4'h1, 8'h00);
  endtask
  // Time-out: 4 chars of 8 bits plus 12 bits is 44 ticks
  task automatic t_timeout;
    @(posedge sys_clk) rx_level <= 7'h01;
    w(4'h1, 8'h01);
    @(posedge sys_clk) bit_tick <= 1'b1;
    repeat (50) @(posedge sys_clk);
    bit_tick <= 1'b0;
    rc(4'h2, 8'hCC);
    rc(4'h0, 8'h00);
    rc(4'h2, 8'hC1);
    @(posedge sys_clk) rx_level <= 7'h00;
    w(4'h1, 8'h08);
    @(posedge sys_clk) modem_delta <= 4'h1;
    rc(4'h2, 8'hC0);
    @(posedge sys_clk) modem_delta <= 4'h0;
    rc(4'h2, 8'hC1);
    @(posedge sys_clk) gpio_in <= 8'h01;
    rc(4'h2, 8'hF0);
    rc(4'hB, 8'h00);
    rc(4'h2, 8'hC1);
  endtask
  // Xoff held until Xon, special cleared by status read
  task automatic t_xoff;
    w(4'h1, 8'h20);
    @(posedge sys_clk) xoff_match <= 1'b1;
    @(posedge sys_clk) xoff_match <= 1'b0;
    rc(4'h2, 8'hD0);
    rc(4'h2, 8'hD0);
    @(posedge sys_clk) xon_match <= 1'b1;
    @(posedge sys_clk) xon_match <= 1'b0;
    rc(4'h2, 8'hC1);
    @(posedge sys_clk) special_match <= 1'b1;
    @(posedge sys_clk) special_match <= 1'b0;
    rc(4'h2, 8'hD0);
    rc(4'h2, 8'hC1);
    w(4'h1, 8'hC0);
    @(posedge sys_clk) auto_rts <= 1'b1;
    auto_cts <= 1'b1;
    rts_n <= 1'b1;
    rc(4'h2, 8'hE0);
    rc(4'h6, 8'h00);
    rc(4'h2, 8'hC1);
    @(posedge sys_clk) cts_n <= 1'b1;
    rc(4'h2, 8'hE0);
    rc(4'h6, 8'h00);
    rc(4'h2, 8'hC1);
  endtask
  task automatic finish_test;
    $display("Checks %0d, errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    {fifo_enable, enhanced_enable, auto_rts, auto_cts, rx_push, rx_overrun, bit_tick, rts_n, cts_n} = '0;
    {transmit_holding_empty, transmit_shift_empty, xoff_match, special_match, xon_match} = '0;
    {rx_level, rx_error_count, tx_spaces, rx_head_error, modem_delta, gpio_in} = '0;
    {rx_trigger, tx_trigger, char_bits} = {7'h08, 7'h08, 4'h8};
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_enh();
    t_rx();
    t_line();
    t_tx();
    t_timeout();
    t_xoff();
    finish_test();
  end
endmodule
